/* File: core/wdg_top.sv */
`timescale 1ns/1ps
// How it works
// RULE1: current count is readable only; register writes never alter it.
// RULE2: after reset the watchdog runs enabled from zero at clock over two.
// RULE3: prescaler divides by two to the power one plus fine plus six coarse.
// RULE4: disable works only before the first end-of-init or service.
// RULE5: hardware reset into boot loader starts disabled; its ending reset re-enables.
// RULE6: an enabled watchdog keeps counting in every CPU state, idle included.
// RULE7: count at maximum overflows, requests reset, drops reset out, sets flag.
// RULE8: bidirectional mode pulls reset in low and records long hardware reset.
// RULE9: reset request waits for a running external bus cycle to finish.
// RULE10: service clears low byte and loads high byte from reload field.
// RULE11: watchdog flag cleared by service and by hardware reset.
// RULE12: malformed service raises protection fault trap and does not service.
// RULE13: end-of-init clears all four reset indication flags.
// RULE14: control: reload 15..8, fine 7, flags 4..1, coarse 0.
// RULE15: service to overflow takes division times (65536 minus reload*256) clocks.
// RULE16: flag bits reset by source; reload and other fields reset to zero.
// RULE17: software should rewrite control before every service.
// RULE18: flag effects per reset source as software, watchdog, short, long.
// RULE19: hardware reset is long if reset in still low at sequence end.
// RULE20: CPU signals service, disable and end-of-init as one-cycle pulses.
module wdg_top (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	input wire logic service_watchdog_op_in,
	input wire logic service_fmt_ok_in,
	input wire logic disable_watchdog_op_in,
	input wire logic end_init_op_in,
	output logic prot_fault_trap_out,
	input wire logic seq_active_in,
	input wire logic seq_src_hw_in,
	input wire logic seq_src_sw_in,
	input wire logic boot_loader_mode_in,
	input wire logic bidir_reset_en_in,
	input wire logic ext_bus_busy_in,
	output logic wdg_reset_req_out,
	output logic reset_out_pin_n_out,
	input wire logic reset_in_pin_n_in,
	output logic reset_in_pin_n_out,
	output logic reset_in_pin_oe_out,
	output logic watchdog_enabled_out
);
	logic [15:0] count_ff;
	logic [7:0] reload_ff;
	logic fine_ff;
	logic coarse_ff;
	logic [3:0] flags_ff;
	logic enabled_ff;
	logic dis_win_ff;
	logic trap_ff;
	logic reset_out_pin_n_ff;
	logic rin_s1_ff;
	logic rin_s2_ff;
	logic [15:0] rdata_ff;
	wdg_pkg::wdg_state_t state_ff;
	wdg_pkg::wdg_state_t nxt_state;
	logic [15:0] nxt_count;
	logic [7:0] nxt_reload;
	logic nxt_fine;
	logic nxt_coarse;
	logic [3:0] nxt_flags;
	logic nxt_enabled;
	logic nxt_dis_win;
	logic nxt_reset_out_pin_n;
	logic [15:0] nxt_rdata;
	logic tick;
	logic [7:0] presc_cnt;
	logic svc_ok;
	logic svc_bad;
	logic count_run;
	logic ovf;
	logic ctrl_wr;
	logic seq_end;
	logic [3:0] trk_flags;
	logic start_en;
	logic [15:0] ctrl_word;
	logic in_run;

	// reset in pin crosses in through two flops
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rin_s1_ff <= 1'b1;
			rin_s2_ff <= 1'b1;
		end else if (ce_in) begin
			rin_s1_ff <= reset_in_pin_n_in;
			rin_s2_ff <= rin_s1_ff;
		end
	end

	// divider restarts on service and during the reset sequence
	wdg_prescaler #(
		.CNT_W(8)
	) u_presc (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.clr_in(seq_active_in | svc_ok),
		.fine_in(fine_ff),
		.coarse_in(coarse_ff),
		.tick_out(tick),
		.cnt_out(presc_cnt)
	);

	// reset source bookkeeping at the end of each internal sequence
	wdg_rst_track u_track (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.seq_active_in(seq_active_in),
		.src_hw_in(seq_src_hw_in),
		.src_sw_in(seq_src_sw_in),
		.src_wdg_in(state_ff == wdg_pkg::ST_SEQ),
		.bidir_in(bidir_reset_en_in),
		.pin_low_in(~rin_s2_ff),
		.bsl_in(boot_loader_mode_in),
		.flags_in(flags_ff),
		.seq_end_out(seq_end),
		.flags_out(trk_flags),
		.start_enabled_out(start_en)
	);

	// command decode; a malformed service only traps
	assign svc_ok = service_watchdog_op_in & service_fmt_ok_in & ~seq_active_in;
	assign svc_bad = service_watchdog_op_in & ~service_fmt_ok_in; // RULE12
	assign in_run = (state_ff == wdg_pkg::ST_RUN);
	// no CPU power state gates the count: idle does not reach this block
	assign count_run = enabled_ff & in_run & tick & ~seq_active_in; // RULE6
	assign ovf = count_run & (count_ff == wdg_pkg::CNT_MAX); // RULE7
	assign ctrl_wr = reg_wr_in & (reg_addr_in == wdg_pkg::CTRL_ADDR) & ~seq_active_in;

	// count: zero in sequence, reload on service, else step up; writes never reach it
	assign nxt_count = seq_active_in ? wdg_pkg::CNT_RESET : // RULE2 RULE1
		svc_ok ? {reload_ff, wdg_pkg::LOW_BYTE_CLEAR} : // RULE10 RULE15
		(count_run & ~ovf) ? count_ff + 16'h0001 : count_ff;

	// control fields clear in any reset, software writes the rest
	assign nxt_reload = seq_active_in ? wdg_pkg::RELOAD_RESET : // RULE16
		ctrl_wr ? reg_wdata_in[wdg_pkg::RELOAD_LSB +: 8] : reload_ff; // RULE14
	assign nxt_fine = seq_active_in ? 1'b0 : ctrl_wr ? reg_wdata_in[wdg_pkg::FINE_BIT] : fine_ff;
	assign nxt_coarse = seq_active_in ? 1'b0 :
		ctrl_wr ? reg_wdata_in[wdg_pkg::COARSE_BIT] : coarse_ff;

	// flags: sequence end sets and wins over any clear in the same cycle
	assign nxt_flags = seq_end ? trk_flags : // RULE16 RULE11
		end_init_op_in ? wdg_pkg::FLAGS_RESET : // RULE13
		svc_ok ? (flags_ff & ~(4'h1 << wdg_pkg::WDF_IDX)) : flags_ff; // RULE11

	// disable honoured only while the window is still open
	assign nxt_enabled = seq_end ? start_en : // RULE2 RULE5
		(disable_watchdog_op_in & dis_win_ff & ~seq_active_in) ? 1'b0 : enabled_ff; // RULE4
	assign nxt_dis_win = seq_end ? 1'b1 : (svc_ok | end_init_op_in) ? 1'b0 : dis_win_ff; // RULE4

	// reset out stays low from overflow until software ends init
	assign nxt_reset_out_pin_n = (ovf | seq_active_in) ? 1'b0 : end_init_op_in ? 1'b1 : reset_out_pin_n_ff;

	// reset handling: wait for the bus, then ride out the sequence
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			wdg_pkg::ST_RUN: begin
				if (ovf) begin
					nxt_state = wdg_pkg::ST_WAIT; // RULE7
				end
			end
			wdg_pkg::ST_WAIT: begin
				if (seq_active_in) begin
					nxt_state = wdg_pkg::ST_SEQ;
				end
			end
			wdg_pkg::ST_SEQ: begin
				if (!seq_active_in) begin
					nxt_state = wdg_pkg::ST_RUN;
				end
			end
			default: begin
				nxt_state = wdg_pkg::ST_RUN;
			end
		endcase
	end

	// request held back while an external bus cycle runs
	assign wdg_reset_req_out = (state_ff == wdg_pkg::ST_WAIT) & ~ext_bus_busy_in; // RULE9
	// open-drain reset in: only ever driven low
	assign reset_in_pin_n_out = 1'b0;
	assign reset_in_pin_oe_out = bidir_reset_en_in & // RULE8
		(~in_run | (seq_active_in & seq_src_sw_in));
	assign reset_out_pin_n_out = reset_out_pin_n_ff; // RULE7
	assign prot_fault_trap_out = trap_ff;
	assign watchdog_enabled_out = enabled_ff;

	// read mux; the data stand for one cycle only
	assign ctrl_word = {reload_ff, fine_ff, 2'b00, flags_ff, coarse_ff}; // RULE14
	assign nxt_rdata = ~reg_rd_in ? 16'h0000 :
		(reg_addr_in == wdg_pkg::CTRL_ADDR) ? ctrl_word :
		(reg_addr_in == wdg_pkg::CNT_ADDR) ? count_ff : 16'h0000; // RULE1
	assign reg_rdata_out = rdata_ff;

	// counter and control state
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_ff <= wdg_pkg::CNT_RESET;
			reload_ff <= wdg_pkg::RELOAD_RESET;
			fine_ff <= 1'b0;
			coarse_ff <= 1'b0;
			state_ff <= wdg_pkg::ST_RUN;
		end else if (ce_in) begin
			count_ff <= nxt_count;
			reload_ff <= nxt_reload;
			fine_ff <= nxt_fine;
			coarse_ff <= nxt_coarse;
			state_ff <= nxt_state;
		end
	end

	// flags, enable window and outputs
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_ff <= wdg_pkg::FLAGS_RESET;
			enabled_ff <= 1'b1;
			dis_win_ff <= 1'b1;
			reset_out_pin_n_ff <= 1'b0;
			trap_ff <= 1'b0;
			rdata_ff <= 16'h0000;
		end else if (ce_in) begin
			flags_ff <= nxt_flags;
			enabled_ff <= nxt_enabled;
			dis_win_ff <= nxt_dis_win;
			reset_out_pin_n_ff <= nxt_reset_out_pin_n;
			trap_ff <= svc_bad;
			rdata_ff <= nxt_rdata;
		end
	end

	// checks on the guarded behaviour
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence ovf_seen;
		ce_in && ovf;
	endsequence

	sequence reset_pending;
		(state_ff == wdg_pkg::ST_WAIT) && !reset_out_pin_n_out;
	endsequence

	property ovf_to_reset;
		ovf_seen |=> reset_pending;
	endproperty

	count_ro_a: assert property (ce_in && reg_wr_in && reg_addr_in == wdg_pkg::CNT_ADDR // RULE1
		&& !count_run && !svc_ok && !seq_active_in |=> $stable(count_ff))
		else $error("count changed by a register write");

	seq_zero_a: assert property (ce_in && seq_active_in |=> count_ff == 16'h0000) // RULE2
		else $error("count not zero after reset sequence");

	seq_ctrl_a: assert property (ce_in && seq_active_in |=> reload_ff == 8'h00 && !fine_ff // RULE16
		&& !coarse_ff)
		else $error("control fields not cleared by reset sequence");

	presc_div_a: assert property (tick |-> presc_cnt >= wdg_pkg::presc_last(fine_ff, coarse_ff)) // RULE3
		else $error("prescaler tick before its division");

	dis_window_a: assert property (ce_in && disable_watchdog_op_in && !dis_win_ff // RULE4
		&& !seq_end |=> enabled_ff == $past(enabled_ff))
		else $error("disable honoured outside its window");

	bsl_start_a: assert property (ce_in && seq_end && seq_src_hw_in && boot_loader_mode_in // RULE5
		|=> !enabled_ff)
		else $error("boot loader reset left watchdog enabled");

	count_step_a: assert property (ce_in && count_run && !ovf && !svc_ok // RULE6
		|=> count_ff == $past(count_ff) + 16'h0001)
		else $error("enabled watchdog failed to count");

	ovf_reset_a: assert property (ovf_to_reset) // RULE7
		else $error("overflow did not raise reset");

	bidir_pull_a: assert property (bidir_reset_en_in && !in_run |-> reset_in_pin_oe_out) // RULE8
		else $error("reset in not pulled in bidirectional mode");

	bus_wait_a: assert property (wdg_reset_req_out |-> !ext_bus_busy_in) // RULE9
		else $error("reset requested during bus cycle");

	svc_reload_a: assert property (ce_in && svc_ok |=> count_ff == {$past(reload_ff), 8'h00} // RULE10
		&& !flags_ff[wdg_pkg::WDF_IDX] || $past(seq_end))
		else $error("service did not reload count");

	bad_svc_a: assert property (ce_in && svc_bad && !seq_active_in && !count_run // RULE12
		|=> prot_fault_trap_out && $stable(count_ff))
		else $error("malformed service not trapped");

	end_init_op_clr_a: assert property (ce_in && end_init_op_in && !seq_end |=> flags_ff == 4'h0) // RULE13
		else $error("end of init left flags set");
endmodule

/* File: pkg/wdg_pkg.sv */
package wdg_pkg;

	// register addresses on the plain register port
	localparam logic [15:0] CTRL_ADDR = 16'hFFAE;
	localparam logic [15:0] CNT_ADDR = 16'hFFAC;

	// control word field positions
	localparam int RELOAD_LSB = 8;
	localparam int FINE_BIT = 7;
	localparam int FLAGS_LSB = 1;
	localparam int COARSE_BIT = 0;

	// flag vector order inside the four-bit flag field
	localparam int LHW_IDX = 3;
	localparam int SHW_IDX = 2;
	localparam int SW_IDX = 1;
	localparam int WDF_IDX = 0;

	// reset values, count maximum and service low byte
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [7:0] LOW_BYTE_CLEAR = 8'h00;

	// prescaler exponent: base plus fine plus coarse step
	localparam logic [3:0] PRE_BASE_EXP = 4'h1;
	localparam logic [3:0] PRE_COARSE_EXP = 4'h6;

	// reset handling state, one-hot
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_WAIT = 3'b010,
		ST_SEQ = 3'b100
	} wdg_state_t;

	// last prescaler count before a tick: 2^(1+fine+6*coarse) - 1
	function automatic logic [7:0] presc_last(input logic fine, input logic coarse);
		logic [3:0] e;
		logic [8:0] d;
		e = PRE_BASE_EXP + {3'h0, fine} + (coarse ? PRE_COARSE_EXP : 4'h0);
		d = 9'h001 << e;
		return d[7:0] - 8'h01;
	endfunction

endpackage

/* File: core/wdg_prescaler.sv */
`timescale 1ns/1ps
module wdg_prescaler #(
	parameter int CNT_W = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic clr_in,
	input wire logic fine_in,
	input wire logic coarse_in,
	output logic tick_out,
	output logic [CNT_W-1:0] cnt_out
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] last;

	// compare with >= so a select change mid-count never runs the divider long
	assign last = CNT_W'(wdg_pkg::presc_last(fine_in, coarse_in)); // RULE3
	assign tick_out = (cnt_ff >= last) & ~clr_in;
	assign nxt_cnt = (clr_in | tick_out) ? '0 : cnt_ff + CNT_W'(1);
	assign cnt_out = cnt_ff;

	// divider count, restarted by service so the period is exact
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_ff <= '0;
		end else if (ce_in) begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

/* File: core/wdg_rst_track.sv */
`timescale 1ns/1ps
module wdg_rst_track (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic seq_active_in,
	input wire logic src_hw_in,
	input wire logic src_sw_in,
	input wire logic src_wdg_in,
	input wire logic bidir_in,
	input wire logic pin_low_in,
	input wire logic bsl_in,
	input wire logic [3:0] flags_in,
	output logic seq_end_out,
	output logic [3:0] flags_out,
	output logic start_enabled_out
);
	logic seq_prev_ff;
	logic [3:0] hw_flags;
	logic [3:0] soft_flags;

	// end of the internal reset sequence is its falling edge
	assign seq_end_out = seq_prev_ff & ~seq_active_in;

	// hardware: long when the pin is still low at the end
	assign hw_flags = {pin_low_in | flags_in[wdg_pkg::LHW_IDX], 1'b1, 1'b1, 1'b0}; // RULE18 RULE19
	// software and watchdog: bidirectional mode also shows a long hardware reset
	assign soft_flags = {flags_in[wdg_pkg::LHW_IDX] | bidir_in, // RULE8
		flags_in[wdg_pkg::SHW_IDX] | bidir_in,
		1'b1,
		flags_in[wdg_pkg::WDF_IDX] | src_wdg_in}; // RULE18
	assign flags_out = src_hw_in ? hw_flags : ((src_sw_in | src_wdg_in) ? soft_flags : flags_in);
	// boot loader entry by hardware reset starts disabled
	assign start_enabled_out = ~(src_hw_in & bsl_in); // RULE5

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			seq_prev_ff <= 1'b0;
		end else if (ce_in) begin
			seq_prev_ff <= seq_active_in;
		end
	end
endmodule

/* File: bench/wdg_seq_model.sv */
`timescale 1ns/1ps
// stand-in for the reset sequencer: answers a watchdog request or a bench trigger
module wdg_seq_model #(
	parameter int SEQ_LEN = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic hw_go_in,
	input wire logic sw_go_in,
	output logic seq_active_out,
	output logic src_hw_out,
	output logic src_sw_out
);
	logic [7:0] len_ff;

	// source levels outlive the sequence so its end cycle still sees them
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			len_ff <= 8'h00;
			seq_active_out <= 1'b0;
			src_hw_out <= 1'b0;
			src_sw_out <= 1'b0;
		end else if (len_ff != 8'h00) begin
			len_ff <= len_ff - 8'h01;
			seq_active_out <= (len_ff != 8'h01);
		end else if (req_in || hw_go_in || sw_go_in) begin
			len_ff <= 8'(SEQ_LEN);
			seq_active_out <= 1'b1;
			src_hw_out <= hw_go_in;
			src_sw_out <= sw_go_in;
		end
	end
endmodule

/* File: bench/wdg_top_tb.sv */
`timescale 1ns/1ps
module wdg_top_tb;
	logic clk, rst, wr, rd, svc, fmt, dis, ein, trap, seq, shw, ssw, boot_loader_mode, bidir, busy;
	logic req, rout_n, pin_n, pin_o, oe, en, pin_drv, hw_go, sw_go, oe_seen, ce;
	logic [15:0] addr, wdata, rdata;
	int failures, samples_checked, cycles;

	// free-running clock, 40 ns
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// open-drain reset-in wire: pulled low by the block or by the bench
	assign pin_n = oe ? pin_o : pin_drv;

	wdg_top i_wdg_top (.ref_clk_in(clk), .rst_in(rst), .ce_in(ce), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.service_watchdog_op_in(svc), .service_fmt_ok_in(fmt), .disable_watchdog_op_in(dis),
		.end_init_op_in(ein), .prot_fault_trap_out(trap), .seq_active_in(seq),
		.seq_src_hw_in(shw), .seq_src_sw_in(ssw), .boot_loader_mode_in(boot_loader_mode),
		.bidir_reset_en_in(bidir), .ext_bus_busy_in(busy), .wdg_reset_req_out(req),
		.reset_out_pin_n_out(rout_n), .reset_in_pin_n_in(pin_n), .reset_in_pin_n_out(pin_o),
		.reset_in_pin_oe_out(oe), .watchdog_enabled_out(en));

	wdg_seq_model i_wdg_seq_model (.ref_clk_in(clk), .rst_in(rst), .req_in(req),
		.hw_go_in(hw_go), .sw_go_in(sw_go), .seq_active_out(seq), .src_hw_out(shw),
		.src_sw_out(ssw));

	task automatic stop_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string name);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(name, exp, rdata);
		@(posedge clk);
	endtask

	// decoded cpu operations arrive as one-cycle pulses
	task automatic op(input logic s, input logic d, input logic e);
		svc <= s;
		dis <= d;
		ein <= e;
		@(posedge clk);
		svc <= 1'b0;
		dis <= 1'b0;
		ein <= 1'b0;
	endtask

	task automatic do_rst();
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	// bounded wait through one sequence, noting whether reset-in was pulled
	task automatic wait_seq();
		int n;
		oe_seen = 1'b0;
		for (n = 0; n < 60 && seq !== 1'b1; n++) @(negedge clk);
		// a sequence that never starts or never ends is a mismatch, not a hang
		if (seq !== 1'b1) begin
			failures++;
			$display("Error seq_start expected 1 seen %b", seq);
		end
		for (n = 0; n < 60 && seq === 1'b1; n++) begin
			oe_seen = oe_seen | oe;
			@(negedge clk);
		end
		if (n >= 60) begin
			failures++;
			$display("Error seq_end expected 0 seen %b", seq);
		end
		repeat (2) @(posedge clk);
	endtask

	task automatic pulse_seq(input logic hw);
		hw_go <= hw;
		sw_go <= !hw;
		@(posedge clk);
		hw_go <= 1'b0;
		sw_go <= 1'b0;
		wait_seq();
	endtask

	// reload FF at divide-by-two: 512 cycles from service to overflow
	task automatic ovf(input logic [15:0] exp);
		int n;
		wr_reg(wdg_pkg::CTRL_ADDR, 16'hFF00);
		op(1'b1, 1'b0, 1'b0);
		busy <= 1'b1;
		for (n = 0; n < 1000 && rout_n === 1'b1; n++) @(negedge clk);
		chk("ovf_time", 16'h0001, {15'h0000, n >= 510 && n <= 515});
		repeat (3) @(posedge clk);
		chk("req_busy", 16'h0000, {15'h0000, req});
		busy <= 1'b0;
		@(negedge clk);
		chk("req", 16'h0001, {15'h0000, req});
		wait_seq();
		chk("pin_pull", {15'h0000, bidir}, {15'h0000, oe_seen});
		rd_chk(wdg_pkg::CTRL_ADDR, exp, "ovf_flags");
	endtask

	// watchdog on hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end

	initial begin
		int i, div;
		logic f, c;
		{wr, rd, svc, dis, ein, boot_loader_mode, bidir, busy, hw_go, sw_go} = '0;
		{addr, wdata} = '0;
		ce = 1'b1;
		fmt = 1'b1;
		pin_drv = 1'b1;
		failures = 0;
		samples_checked = 0;
		cycles = 0;
		// reset from time zero so no flop runs unknown before it
		do_rst();
		rd_chk(wdg_pkg::CTRL_ADDR, 16'h0000, "ctrl_reset");
		chk("en_reset", 16'h0001, {15'h0000, en});
		// malformed service traps and leaves the disable window open
		fmt <= 1'b0;
		op(1'b1, 1'b0, 1'b0);
		@(negedge clk);
		chk("trap", 16'h0001, {15'h0000, trap});
		@(posedge clk);
		fmt <= 1'b1;
		op(1'b0, 1'b1, 1'b0);
		@(negedge clk);
		chk("en_dis", 16'h0000, {15'h0000, en});
		@(posedge clk);
		// after end-of-init a disable is ignored
		do_rst();
		op(1'b0, 1'b0, 1'b1);
		@(posedge clk);
		op(1'b0, 1'b1, 1'b0);
		@(negedge clk);
		chk("en_kept", 16'h0001, {15'h0000, en});
		chk("rout_up", 16'h0001, {15'h0000, rout_n});
		@(posedge clk);
		wr_reg(wdg_pkg::CTRL_ADDR, 16'hFF9F);
		rd_chk(wdg_pkg::CTRL_ADDR, 16'hFF81, "ctrl_layout");
		// every prescaler setting, three counts after a service at reload 12
		for (i = 0; i < 4; i++) begin
			f = i[0];
			c = i[1];
			div = 2 << (f + 6 * c);
			wr_reg(wdg_pkg::CTRL_ADDR, {8'h12, f, 6'h00, c});
			op(1'b1, 1'b0, 1'b0);
			wr_reg(wdg_pkg::CNT_ADDR, 16'hFFFF);
			// five frozen edges must move neither the count nor the divider
			ce <= 1'b0;
			repeat (5) @(posedge clk);
			ce <= 1'b1;
			repeat (div * 3 - 1) @(posedge clk);
			rd_chk(wdg_pkg::CNT_ADDR, 16'h1203, "count");
		end
		ovf(16'h0006);
		op(1'b1, 1'b0, 1'b0);
		rd_chk(wdg_pkg::CTRL_ADDR, 16'h0004, "svc_clr");
		op(1'b0, 1'b0, 1'b1);
		rd_chk(wdg_pkg::CTRL_ADDR, 16'h0000, "end_init_op_clr");
		bidir <= 1'b1;
		ovf(16'h001E);
		bidir <= 1'b0;
		op(1'b0, 1'b0, 1'b1);
		// boot loader start, then the software reset that ends it
		boot_loader_mode <= 1'b1;
		pulse_seq(1'b1);
		chk("en_bsl", 16'h0000, {15'h0000, en});
		rd_chk(wdg_pkg::CTRL_ADDR, 16'h000C, "short_hw");
		boot_loader_mode <= 1'b0;
		pulse_seq(1'b0);
		chk("en_sw", 16'h0001, {15'h0000, en});
		pin_drv <= 1'b0;
		pulse_seq(1'b1);
		pin_drv <= 1'b1;
		rd_chk(wdg_pkg::CTRL_ADDR, 16'h001C, "long_hw");
		stop_test();
	end
endmodule
